// *** pkg/gpp_pkg.sv ***
// Package: register map, field positions and timing for the parallel device port
package gpp_pkg;

  // Register byte offsets
  localparam logic [7:0] GPP_OFF_CTRL   = 8'h00;
  localparam logic [7:0] GPP_OFF_OUTBUF = 8'h04;
  localparam logic [7:0] GPP_OFF_INBUF  = 8'h08;
  localparam logic [7:0] GPP_OFF_STAT   = 8'h0C;
  localparam logic [7:0] GPP_OFF_MASK   = 8'h10;

  // Control register fields
  localparam int GPP_CTRL_ENA   = 0;
  localparam int GPP_CTRL_ENB   = 1;
  localparam int GPP_CTRL_CONTROL_OUT_0  = 2;
  localparam int GPP_CTRL_CONTROL_OUT_1  = 3;
  localparam int GPP_CTRL_FLAGA = 4;
  localparam int GPP_CTRL_FLAGB = 5;
  localparam int GPP_CTRL_W     = 6;

  // Status / mask fields
  localparam int GPP_ST_REQA = 0;
  localparam int GPP_ST_REQB = 1;
  localparam int GPP_ST_W    = 2;

  localparam int GPP_DATA_W = 16;

  // AXI responses
  localparam logic [1:0] GPP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] GPP_RESP_SLVERR = 2'h2;

  // Strobe width: 400 ns at 25 MHz, rounded up
  localparam int GPP_CLK_NS      = 40;
  localparam int GPP_STROBE_NS   = 400;
  localparam int GPP_STROBE_CYC  = (GPP_STROBE_NS + GPP_CLK_NS - 1) / GPP_CLK_NS;
  localparam int GPP_STROBE_CW   = 4;

endpackage

// *** hw/gpp_pulse.sv ***
// Fixed-width strobe generator, one pulse per trigger outside a running pulse
`timescale 1ns/1ps
`default_nettype none
module gpp_pulse
  import gpp_pkg::*;
#(
  parameter logic [GPP_STROBE_CW-1:0] WIDTH = GPP_STROBE_CW'(GPP_STROBE_CYC)
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic trig,
  output var  logic pulse
);

  typedef struct packed {
    logic                     on;
    logic [GPP_STROBE_CW-1:0] cnt;
  } gpp_pulse_s;

  gpp_pulse_s st;
  gpp_pulse_s next_st;

  // A trigger during a running pulse restarts it, so overlapping accesses share one stretched pulse
  always_comb begin
    next_st = st;
    if (trig) begin
      next_st.on  = 1'b1;
      next_st.cnt = WIDTH;
    end else if (st.on) begin
      next_st.cnt = st.cnt - GPP_STROBE_CW'(1);
      if (st.cnt == GPP_STROBE_CW'(1)) begin
        next_st.on = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.on;

endmodule
`default_nettype wire

// *** hw/gpp_port.sv ***
// Top: 16-bit parallel device port with AXI4-Lite register access
//
// Behaviour
// RULE1 - Request A raises the interrupt only while its enable bit is set.
// RULE2 - Request B (error line) raises the interrupt only while its enable bit is set.
// RULE3 - With an enable off, the request level is still readable as a polled flag.
// RULE4 - Each write of the output buffer sends one new-data strobe to the device; writes within one strobe width share one stretched strobe here.
// RULE5 - Each read of the input buffer sends one data-taken strobe to the device; reads within one strobe width share one stretched strobe here.
// RULE6 - The device drives requests as active-high levels held through the service.
// RULE7 - The device keeps each request in a flip-flop cleared by a port strobe.
// RULE8 - The device may set its request flip-flop on an edge of its own request.
// RULE9 - Two software control bits drive two output lines directly.
// RULE10 - Back to back, data outputs feed data inputs and controls feed requests.
// RULE11 - Back to back, a control bit raises the far request, then data follows.
// RULE12 - Strobes are about 400 ns wide, width adjustable.
// RULE13 - Requests are synchronised first; exactly one strobe per buffer access; accesses within one strobe width share one strobe here.
`timescale 1ns/1ps
`default_nettype none
module gpp_port
  import gpp_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [GPP_DATA_W-1:0] data_in,
  input  wire logic                  request_first,
  input  wire logic                  request_second,
  output var  logic [GPP_DATA_W-1:0] data_out,
  output var  logic                  control_out_0,
  output var  logic                  control_out_1,
  output var  logic                  new_data_pulse,
  output var  logic                  input_taken_pulse,
  output var  logic                  irq
);

  typedef struct packed {
    logic                  aw_hold;
    logic [7:0]            aw_addr;
    logic                  w_hold;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [1:0]            req_s1;
    logic [1:0]            req_s2;
    logic [1:0]            req_d;
    logic                  irq_enable_first;
    logic                  irq_enable_second;
    logic                  ctl0;
    logic                  ctl1;
    logic [GPP_DATA_W-1:0] output_buffer;
    logic [GPP_ST_W-1:0]   status;
    logic [GPP_ST_W-1:0]   mask;
    logic                  irq;
    logic                  load_trig;
    logic                  take_trig;
    logic [GPP_STROBE_CW-1:0] nd_run;
  } gpp_port_s;

  gpp_port_s st;
  gpp_port_s next_st;

  logic nd_pulse;
  logic tk_pulse;

  // Byte-lane merge for a 32-bit register word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  // Address decode shared by both channels
  function automatic logic mapped(input logic [7:0] a);
    return (a == GPP_OFF_CTRL) || (a == GPP_OFF_OUTBUF) || (a == GPP_OFF_INBUF) ||
           (a == GPP_OFF_STAT) || (a == GPP_OFF_MASK);
  endfunction

  logic [31:0] ctrl_word;
  logic [31:0] wm;
  logic        do_wr;
  logic        do_rd;
  logic [GPP_ST_W-1:0] ev;
  logic [GPP_ST_W-1:0] clr;

  // Next-state logic: bus slave, register file, sync and interrupt
  always_comb begin
    next_st = st;
    ctrl_word = '0;
    ctrl_word[GPP_CTRL_ENA]   = st.irq_enable_first;
    ctrl_word[GPP_CTRL_ENB]   = st.irq_enable_second;
    ctrl_word[GPP_CTRL_CONTROL_OUT_0]  = st.ctl0;
    ctrl_word[GPP_CTRL_CONTROL_OUT_1]  = st.ctl1;
    ctrl_word[GPP_CTRL_FLAGA] = st.req_s2[0];                   // [RULE3]
    ctrl_word[GPP_CTRL_FLAGB] = st.req_s2[1];                   // [RULE3]
    next_st.load_trig = 1'b0;
    next_st.take_trig = 1'b0;
    clr = '0;

    // Two-stage synchroniser; stage one feeds only stage two
    next_st.req_s1 = {request_second, request_first};          // [RULE13]
    next_st.req_s2 = st.req_s1;
    next_st.req_d  = st.req_s2;

    // Accept address and data independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end

    // Write executes once both halves are held and no response is pending
    do_wr = st.aw_hold && st.w_hold && !st.bvalid;
    wm = '0;
    if (do_wr) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = mapped(st.aw_addr) ? GPP_RESP_OKAY : GPP_RESP_SLVERR;
      if (st.aw_addr == GPP_OFF_CTRL) begin
        wm = wmerge(ctrl_word, st.w_data, st.w_strb);
        next_st.irq_enable_first  = wm[GPP_CTRL_ENA];
        next_st.irq_enable_second = wm[GPP_CTRL_ENB];
        next_st.ctl0 = wm[GPP_CTRL_CONTROL_OUT_0];                      // [RULE9]
        next_st.ctl1 = wm[GPP_CTRL_CONTROL_OUT_1];                      // [RULE9]
      end else if (st.aw_addr == GPP_OFF_OUTBUF) begin
        wm = wmerge({16'h0000, st.output_buffer}, st.w_data, st.w_strb);
        next_st.output_buffer = wm[GPP_DATA_W-1:0];
        next_st.load_trig = 1'b1;                              // [RULE4] [RULE13]
      end else if (st.aw_addr == GPP_OFF_STAT) begin
        if (st.w_strb[0]) clr = st.w_data[GPP_ST_W-1:0];
      end else if (st.aw_addr == GPP_OFF_MASK) begin
        wm = wmerge({30'h0000_0000, st.mask}, st.w_data, st.w_strb);
        next_st.mask = wm[GPP_ST_W-1:0];
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Read: one cycle from address handshake to data
    do_rd = s_axi_arvalid && s_axi_arready;
    if (do_rd) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = mapped(s_axi_araddr) ? GPP_RESP_OKAY : GPP_RESP_SLVERR;
      next_st.rdata  = '0;
      if (s_axi_araddr == GPP_OFF_CTRL) begin
        next_st.rdata = ctrl_word;
      end else if (s_axi_araddr == GPP_OFF_OUTBUF) begin
        next_st.rdata = {16'h0000, st.output_buffer};
      end else if (s_axi_araddr == GPP_OFF_INBUF) begin
        next_st.rdata = {16'h0000, data_in};
        next_st.take_trig = 1'b1;                              // [RULE5] [RULE13]
      end else if (s_axi_araddr == GPP_OFF_STAT) begin
        next_st.rdata = {30'h0000_0000, st.status};
      end else if (s_axi_araddr == GPP_OFF_MASK) begin
        next_st.rdata = {30'h0000_0000, st.mask};
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // Request rising edge, gated by enable, sets sticky status; set beats clear
    ev = st.req_s2 & ~st.req_d;
    ev[GPP_ST_REQA] = ev[GPP_ST_REQA] & st.irq_enable_first;  // [RULE1]
    ev[GPP_ST_REQB] = ev[GPP_ST_REQB] & st.irq_enable_second; // [RULE2]
    next_st.status = (st.status & ~clr) | ev;
    next_st.irq = |(next_st.status & next_st.mask);           // [RULE1] [RULE2]

    // Length of the new-data strobe since its last load, so the width check survives restarts
    if (st.load_trig) begin
      next_st.nd_run = '0;
    end else if (new_data_pulse) begin
      next_st.nd_run = st.nd_run + GPP_STROBE_CW'(1);
    end else begin
      next_st.nd_run = '0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Strobe stretchers, about 400 ns each
  gpp_pulse u_new_data (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trig    (st.load_trig),
    .pulse   (nd_pulse)
  );                                                           // [RULE12]

  gpp_pulse u_taken (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trig    (st.take_trig),
    .pulse   (tk_pulse)
  );                                                           // [RULE12]

  // Outputs straight from flip-flops
  assign s_axi_awready     = !st.aw_hold;
  assign s_axi_wready      = !st.w_hold;
  assign s_axi_bvalid      = st.bvalid;
  assign s_axi_bresp       = st.bresp;
  assign s_axi_arready     = !st.rvalid;
  assign s_axi_rvalid      = st.rvalid;
  assign s_axi_rdata       = st.rdata;
  assign s_axi_rresp       = st.rresp;
  assign data_out          = st.output_buffer;                 // [RULE10]
  assign control_out_0     = st.ctl0;                          // [RULE11]
  assign control_out_1     = st.ctl1;
  assign new_data_pulse    = nd_pulse;
  assign input_taken_pulse = tk_pulse;
  assign irq               = st.irq;

  // Checks
  property p_strobe_width;
    @(posedge aclk) disable iff (!aresetn)
      $fell(new_data_pulse) |-> st.nd_run == GPP_STROBE_CW'(GPP_STROBE_CYC);
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong"); // [RULE12]

  property p_nd_after_write;
    @(posedge aclk) disable iff (!aresetn)
      (do_wr && st.aw_addr == GPP_OFF_OUTBUF) |-> ##2 new_data_pulse;
  endproperty
  a_nd_after_write: assert property (p_nd_after_write) else $error("no new-data strobe"); // [RULE4]

  property p_tk_after_read;
    @(posedge aclk) disable iff (!aresetn)
      (do_rd && s_axi_araddr == GPP_OFF_INBUF) |-> ##2 input_taken_pulse;
  endproperty
  a_tk_after_read: assert property (p_tk_after_read) else $error("no taken strobe"); // [RULE5]

  property p_one_strobe;
    @(posedge aclk) disable iff (!aresetn)
      $rose(input_taken_pulse) |-> $past(st.take_trig);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("strobe without access"); // [RULE13]

  property p_irqa_gated;
    @(posedge aclk) disable iff (!aresetn)
      (!st.irq_enable_first && !st.status[GPP_ST_REQA]) |=> !st.status[GPP_ST_REQA];
  endproperty
  a_irqa_gated: assert property (p_irqa_gated) else $error("A set while disabled"); // [RULE1]

  property p_irqb_set;
    @(posedge aclk) disable iff (!aresetn)
      ($rose(st.req_s2[1]) && st.irq_enable_second) |=> st.status[GPP_ST_REQB];
  endproperty
  a_irqb_set: assert property (p_irqb_set) else $error("B event lost"); // [RULE2]

  property p_flag_poll;
    @(posedge aclk) disable iff (!aresetn)
      $rose(request_first) |-> ##2 ctrl_word[GPP_CTRL_FLAGA];
  endproperty
  a_flag_poll: assert property (p_flag_poll) else $error("flag not visible"); // [RULE3]

  property p_ctl_out;
    @(posedge aclk) disable iff (!aresetn)
      (do_wr && st.aw_addr == GPP_OFF_CTRL && st.w_strb[0])
        |=> control_out_1 == st.w_data[GPP_CTRL_CONTROL_OUT_1] && control_out_0 == st.w_data[GPP_CTRL_CONTROL_OUT_0];
  endproperty
  a_ctl_out: assert property (p_ctl_out) else $error("control lines wrong"); // [RULE9]

  property p_irq_out;
    @(posedge aclk) disable iff (!aresetn)
      (do_wr && st.aw_addr == GPP_OFF_STAT && st.w_strb[0] && ev == '0 &&
       (st.status & ~st.w_data[GPP_ST_W-1:0]) == '0) |=> !irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq mismatch"); // [RULE1]

  c_write: cover property (@(posedge aclk) disable iff (!aresetn) new_data_pulse);
  c_read:  cover property (@(posedge aclk) disable iff (!aresetn) input_taken_pulse);
  // Main scenarios: both strobes, interrupt raised and cleared, request seen only as a flag
  c_irq:   cover property (@(posedge aclk) disable iff (!aresetn) irq);
  c_irq_clear: cover property (@(posedge aclk) disable iff (!aresetn) $fell(irq));
  c_flag_only: cover property (@(posedge aclk) disable iff (!aresetn)
    st.req_s2[GPP_ST_REQA] && !st.irq_enable_first);

endmodule
`default_nettype wire

// *** tb/gpp_dev_model.sv ***
// Partner model: the external device's request flip-flops
`timescale 1ns/1ps
`default_nettype none
module gpp_dev_model
  import gpp_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic new_data_pulse,
  input  wire logic input_taken_pulse,
  input  wire logic want_first,
  input  wire logic want_second,
  output var  logic request_first,
  output var  logic request_second
);
  logic want_first_q;
  logic want_second_q;

  // Requests are held levels; a strobe clears them, a fresh want edge wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      want_first_q   <= 1'b0;
      want_second_q  <= 1'b0;
      request_first  <= 1'b0;
      request_second <= 1'b0;
    end else begin
      want_first_q  <= want_first;
      want_second_q <= want_second;
      if (new_data_pulse || input_taken_pulse) begin
        request_first  <= 1'b0;
        request_second <= 1'b0;
      end
      if (want_first && !want_first_q) request_first <= 1'b1;
      if (want_second && !want_second_q) request_second <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_gpp_port.sv ***
// Testbench: register sequences against the parallel device port
`timescale 1ns/1ps
`default_nettype none
module tb_gpp_port
  import gpp_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [GPP_DATA_W-1:0] data_in = 16'h0000;
  logic [GPP_DATA_W-1:0] data_out;
  logic request_first, request_second, control_out_0, control_out_1;
  logic new_data_pulse, input_taken_pulse, irq;
  logic want_first = 1'b0, want_second = 1'b0;
  logic nd_q = 1'b0, it_q = 1'b0;
  int n_errors = 0, checks_done = 0;
  int nd_hi = 0, nd_up = 0, it_hi = 0, it_up = 0, b0, b1, b2, b3;

  always #20 aclk = ~aclk;

  gpp_port u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_in,
    .request_first, .request_second, .data_out, .control_out_0, .control_out_1,
    .new_data_pulse, .input_taken_pulse, .irq);
  gpp_dev_model u_dev (.aclk, .aresetn, .new_data_pulse, .input_taken_pulse,
    .want_first, .want_second, .request_first, .request_second);

  // Strobe width and edge counters, cumulative so scenarios take differences
  always @(posedge aclk) begin
    nd_q <= new_data_pulse;
    it_q <= input_taken_pulse;
    if (new_data_pulse) nd_hi++;
    if (new_data_pulse && !nd_q) nd_up++;
    if (input_taken_pulse) it_hi++;
    if (input_taken_pulse && !it_q) it_up++;
  end

  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 100) begin
      n_errors++;
      results();
    end
    chk(s_axi_bresp, er);
    // An edge between calls keeps the next call from reassigning these signals at once
    w(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 100) begin
      n_errors++;
      results();
    end
    chk(s_axi_rresp, er);
    chk(s_axi_rdata, ex);
    w(1);
  endtask

  // Snapshot strobe counters, let any strobe finish, compare the increments
  task automatic snap();
    b0 = nd_hi;
    b1 = nd_up;
    b2 = it_hi;
    b3 = it_up;
  endtask

  task automatic strobes(input int nd, input int it);
    w(30);
    chk(nd_hi - b0, nd * GPP_STROBE_CYC);
    chk(nd_up - b1, nd);
    chk(it_hi - b2, it * GPP_STROBE_CYC);
    chk(it_up - b3, it);
  endtask

  initial begin
    w(10);
    aresetn <= 1'b1;
    w(1);
    rd(GPP_OFF_CTRL, 32'h0000_0000, GPP_RESP_OKAY);
    rd(GPP_OFF_STAT, 32'h0000_0000, GPP_RESP_OKAY);
    rd(GPP_OFF_MASK, 32'h0000_0000, GPP_RESP_OKAY);
    chk({irq, data_out}, 32'h0000_0000);
    // Every two-bit operation code reaches the control lines
    for (int c = 0; c < 4; c++) begin
      wr(GPP_OFF_CTRL, 32'(c) << GPP_CTRL_CONTROL_OUT_0, GPP_RESP_OKAY);
      chk({control_out_1, control_out_0}, 32'(c));
      rd(GPP_OFF_CTRL, 32'(c) << GPP_CTRL_CONTROL_OUT_0, GPP_RESP_OKAY);
    end
    snap();
    wr(GPP_OFF_OUTBUF, 32'h0000_a5c3, GPP_RESP_OKAY);
    strobes(1, 0);
    chk(data_out, 32'h0000_a5c3);
    data_in <= 16'h3c96;
    snap();
    rd(GPP_OFF_INBUF, 32'h0000_3c96, GPP_RESP_OKAY);
    strobes(0, 1);
    // Unmapped place is refused, no strobe side effect
    snap();
    rd(8'h14, 32'h0000_0000, GPP_RESP_SLVERR);
    wr(8'h14, 32'h0000_ffff, GPP_RESP_SLVERR);
    strobes(0, 0);
    // Enables off: request is only a polled flag
    wr(GPP_OFF_CTRL, 32'h0000_0000, GPP_RESP_OKAY);
    wr(GPP_OFF_MASK, 32'h0000_0003, GPP_RESP_OKAY);
    want_first <= 1'b1;
    w(8);
    rd(GPP_OFF_CTRL, 32'h0000_0010, GPP_RESP_OKAY);
    rd(GPP_OFF_STAT, 32'h0000_0000, GPP_RESP_OKAY);
    chk(irq, 1'b0);
    rd(GPP_OFF_INBUF, 32'h0000_3c96, GPP_RESP_OKAY);
    want_first <= 1'b0;
    w(30);
    // First request with its enable on raises the interrupt
    wr(GPP_OFF_CTRL, 32'h0000_0001, GPP_RESP_OKAY);
    want_first <= 1'b1;
    w(8);
    chk(irq, 1'b1);
    rd(GPP_OFF_STAT, 32'h0000_0001, GPP_RESP_OKAY);
    rd(GPP_OFF_INBUF, 32'h0000_3c96, GPP_RESP_OKAY);
    wr(GPP_OFF_STAT, 32'h0000_0001, GPP_RESP_OKAY);
    w(3);
    chk(irq, 1'b0);
    want_first <= 1'b0;
    // Second request: status sets, the mask gates the output
    wr(GPP_OFF_CTRL, 32'h0000_0002, GPP_RESP_OKAY);
    wr(GPP_OFF_MASK, 32'h0000_0001, GPP_RESP_OKAY);
    want_second <= 1'b1;
    w(8);
    chk(irq, 1'b0);
    rd(GPP_OFF_STAT, 32'h0000_0002, GPP_RESP_OKAY);
    wr(GPP_OFF_MASK, 32'h0000_0003, GPP_RESP_OKAY);
    w(3);
    chk(irq, 1'b1);
    wr(GPP_OFF_OUTBUF, 32'h0000_0001, GPP_RESP_OKAY);
    wr(GPP_OFF_STAT, 32'h0000_0002, GPP_RESP_OKAY);
    w(3);
    chk(irq, 1'b0);
    rd(GPP_OFF_STAT, 32'h0000_0000, GPP_RESP_OKAY);
    results();
  end
endmodule
`default_nettype wire
